// file: hdl/xcvr_ctrl.sv
// transceiver control logic: bus symbol mapping, wake detection, error pin and status read-out
//
// Functional notes
// RULE1: low-power idle, idle, or data per guardian/enable
// RULE2: receive pins follow bus or wake flag
// RULE3: guardian disables transmitter; activity shows bus idle
// RULE4: inhibit driven high except in sleep
// RULE5: low-power modes watch bus for remote wake
// RULE6: pattern begun in normal power still wakes
// RULE7: two data0 with idle or data1 between
// RULE8: listed 10 Mbit/s payload frame also wakes
// RULE9: all three remote wake forms handled alike
// RULE10: filtered falling wake pin gives local wake
// RULE11: wake pin bias follows filtered level
// RULE12: error pin shows error or wake by mode
// RULE13: error pin low when shown flag set
// RULE14: receive-only shows error or wake source
// RULE15: status shifted out inverted on mode pin falls
// RULE16: toggling mode pin holds mode during read-out
// RULE17: stable mode pin ends read-out, mode changes
// RULE18: clear read S4..S10 whose flags are gone
// RULE19: read-out starts at S0, any length
// RULE20: error flag ORs faults, timeout, undervoltages
// RULE21: long transmit enable sets timeout, blocks transmitter
// RULE22: wake flag forces standby, clears undervoltage
// RULE23: host samples error pin after falls, inverts
`timescale 1ns/1ps
module xcvr_ctrl #(
  parameter int         TX_LIMIT_CYC = xcvr_ctrl_pkg::TX_ACTIVE_LIMIT_CYC,
  parameter logic [7:0] VER_ANALOG   = 8'h11, // arbitrary value
  parameter logic [7:0] VER_DIGITAL  = 8'h22  // arbitrary value
) (
  input  wire logic                      clk_sys_i,
  input  wire logic                      srst_i,
  input  wire xcvr_ctrl_pkg::op_mode_t   op_mode_i,
  input  wire xcvr_ctrl_pkg::pins_t      pins_i,
  input  wire xcvr_ctrl_pkg::flags_t     flags_i,
  output logic [1:0]                     tx_sym_o,
  output logic                           rxd_o,
  output logic                           receive_activity_n_o,
  output logic                           regulator_inhibit_out_o,
  output logic                           regulator_inhibit_out_oe_o,
  output logic                           error_out_n_o,
  output logic                           wake_pull_up_o,
  output logic                           tx_timeout_o,
  output logic                           error_flag_o,
  output logic                           force_standby_o,
  output logic                           uv_clear_o,
  output logic                           mode_hold_o,
  output logic                           readout_done_o,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [7:0]                paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic [31:0]                    prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o
);
  import xcvr_ctrl_pkg::*;

  // ***************************************************************
  // sizes and checks
  // ***************************************************************
  localparam int TOW = $clog2(TX_LIMIT_CYC + 1);
  localparam int WFW = $clog2(WAKE_FILTER_CYC + 1);
  localparam int MCW = $clog2(MODE_CHANGE_CYC + 1);
  localparam int PMW = $clog2(PAT_PHASE_MIN_CYC + 1);
  localparam int PWW = $clog2(PAT_WINDOW_CYC + 1);

  localparam logic [TOW-1:0] TO_LIMIT  = TOW'(TX_LIMIT_CYC);
  localparam logic [WFW-1:0] WF_LIMIT  = WFW'(WAKE_FILTER_CYC);
  localparam logic [MCW-1:0] MC_LIMIT  = MCW'(MODE_CHANGE_CYC);
  localparam logic [PMW-1:0] PAT_MIN   = PMW'(PAT_PHASE_MIN_CYC);
  localparam logic [PWW-1:0] PAT_WIN   = PWW'(PAT_WINDOW_CYC);
  localparam logic [3:0]     FR_BIT    = 4'(FRAME_BIT_CYC - 1);
  localparam logic [3:0]     FR_FIRST  = 4'(FRAME_BIT_CYC + FRAME_BIT_CYC / 2 - 1);
  localparam logic [4:0]     FR_LAST   = 5'(FRAME_BYTES - 1);

  if (TX_LIMIT_CYC < 1) begin : g_chk_limit
    $error("transmit enable limit must be at least one cycle");
  end
  if (FRAME_BIT_CYC < 2 || FRAME_BIT_CYC > 10) begin : g_chk_frame
    $error("frame bit time out of range of the sampler");
  end

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    pins_t          sync1;
    pins_t          sync2;
    pins_t          prev;
    logic [TOW-1:0] to_cnt;
    logic           timeout;
    logic [WFW-1:0] wk_cnt;
    logic           wake_filt;
    logic           local_wake;
    logic           remote_wake;
    logic           remote_last;
    logic           mode_pin_since_wake;
    pat_state_t     pat;
    logic [PMW-1:0] pat_cnt;
    logic [PWW-1:0] pat_age;
    logic           fr_active;
    logic [3:0]     fr_cnt;
    logic [3:0]     fr_bits;
    logic [7:0]     fr_shift;
    logic [4:0]     fr_idx;
    logic           ro_active;
    logic [4:0]     ro_idx;
    logic [31:0]    ro_read;
    logic [MCW-1:0] mc_cnt;
    logic           ro_bit_n;
    logic           ro_done;
    logic [ST_LATCH_HI:ST_LATCH_LO] shadow;
    logic           bge_latch;
    tx_sym_t        tx;
    logic           rxd;
    logic           rxact_n;
    logic           err_n;
    logic           inh_oe;
    logic           wake_pulse;
    logic [1:0]     ctrl;
    logic [31:0]    prdata;
    logic           slverr;
  } state_t;

  state_t r_reg;
  state_t r_next;

  // ***************************************************************
  // decoders
  // ***************************************************************
  function automatic logic rx_bit(input bus_sym_t s);
    rx_bit = (s != SYM_DATA0);
  endfunction : rx_bit

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == REG_CTRL_OFS) || (a == REG_FLAGS_OFS) ||
                  (a == REG_WAKE_CLR_OFS) || (a == REG_STATUS_OFS);
  endfunction : addr_mapped

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    logic        low_power;
    logic        normal;
    logic        tx_allowed;
    logic        err_flag;
    logic        wake_flag;
    logic        mode_fall;
    logic        mode_rise;
    logic        local_ev;
    logic        pattern_hit;
    logic        frame_hit;
    logic        remote_ev;
    logic        clr_local;
    logic        clr_remote;
    logic        wr_acc;
    logic [7:0]  exp_byte;
    logic [31:0] status;
    logic [ST_LATCH_HI:ST_LATCH_LO] latch_set;
    logic [ST_LATCH_HI:ST_LATCH_LO] latch_clr;
    r_next      = r_reg;
    low_power   = (op_mode_i == MODE_STANDBY) || (op_mode_i == MODE_GOTOSLEEP) ||
                  (op_mode_i == MODE_SLEEP);
    normal      = (op_mode_i == MODE_NORMAL);
    pattern_hit = 1'b0;
    frame_hit   = 1'b0;
    local_ev    = 1'b0;
    exp_byte    = WAKE_FRAME_MAP[r_reg.fr_idx] ? 8'hff : 8'h00;
    wr_acc      = psel_i && penable_i && pwrite_i;
    mode_fall   = r_reg.prev.mode_pin && !r_reg.sync2.mode_pin;
    mode_rise   = !r_reg.prev.mode_pin && r_reg.sync2.mode_pin;

    // pin synchronisers
    r_next.sync1 = pins_i;
    r_next.sync2 = r_reg.sync1;
    r_next.prev  = r_reg.sync2;

    // transmit enable timeout
    if (normal && !r_reg.sync2.transmit_enable_n) begin
      if (r_reg.to_cnt < TO_LIMIT) begin
        r_next.to_cnt = r_reg.to_cnt + 1'b1;
      end else begin
        r_next.timeout = 1'b1; // RULE21
      end
    end else begin
      r_next.to_cnt  = '0;
      r_next.timeout = 1'b0;
    end

    err_flag = r_reg.timeout || flags_i.bus_error || flags_i.thermal_warning || // RULE20
               flags_i.thermal_shutdown || flags_i.uv_bat || flags_i.uv_cc || flags_i.uv_io;

    // transmitter
    tx_allowed = normal && r_reg.sync2.guardian_tx_enable && // RULE3
                 !r_reg.sync2.transmit_enable_n && !r_reg.timeout && // RULE21
                 !flags_i.thermal_shutdown;
    if (low_power) begin
      r_next.tx = TX_LOW_POWER_IDLE; // RULE1
    end else if (!tx_allowed) begin
      r_next.tx = TX_IDLE; // RULE1
    end else begin
      r_next.tx = r_reg.sync2.txd ? TX_DATA1 : TX_DATA0; // RULE1
    end
    r_next.inh_oe = (op_mode_i != MODE_SLEEP); // RULE4

    // wake pin filter and bias
    if (r_reg.sync2.wake_pin == r_reg.wake_filt) begin
      r_next.wk_cnt = '0;
    end else if (r_reg.wk_cnt < WF_LIMIT) begin
      r_next.wk_cnt = r_reg.wk_cnt + 1'b1;
    end else begin
      r_next.wk_cnt    = '0;
      r_next.wake_filt = r_reg.sync2.wake_pin; // RULE11
      local_ev         = low_power && !r_reg.sync2.wake_pin; // RULE10
    end

    // wake pattern detector, runs in every mode so a pattern begun earlier still counts
    if (r_reg.pat != PAT_HUNT) begin
      r_next.pat_age = r_reg.pat_age + 1'b1;
    end
    case (r_reg.pat)
      PAT_HUNT: begin
        if (r_reg.sync2.rx_sym == SYM_DATA0) begin
          r_next.pat     = PAT_FIRST_D0;
          r_next.pat_cnt = '0;
          r_next.pat_age = '0;
        end
      end
      PAT_FIRST_D0: begin
        if (r_reg.sync2.rx_sym == SYM_DATA0) begin
          if (r_reg.pat_cnt < PAT_MIN) r_next.pat_cnt = r_reg.pat_cnt + 1'b1;
        end else if (r_reg.pat_cnt >= PAT_MIN) begin
          r_next.pat     = PAT_GAP; // RULE7
          r_next.pat_cnt = '0;
        end else begin
          r_next.pat = PAT_HUNT;
        end
      end
      PAT_GAP: begin
        if (r_reg.sync2.rx_sym != SYM_DATA0) begin
          if (r_reg.pat_cnt < PAT_MIN) r_next.pat_cnt = r_reg.pat_cnt + 1'b1;
        end else begin
          r_next.pat     = (r_reg.pat_cnt >= PAT_MIN) ? PAT_SECOND_D0 : PAT_FIRST_D0; // RULE7
          r_next.pat_cnt = '0;
        end
      end
      PAT_SECOND_D0: begin
        if (r_reg.sync2.rx_sym != SYM_DATA0) begin
          r_next.pat = PAT_HUNT;
        end else if (r_reg.pat_cnt < PAT_MIN) begin
          r_next.pat_cnt = r_reg.pat_cnt + 1'b1;
        end else begin
          pattern_hit = 1'b1; // RULE7
          r_next.pat  = PAT_HUNT;
        end
      end
      default: r_next.pat = PAT_HUNT;
    endcase
    if (r_reg.pat != PAT_HUNT && r_reg.pat_age >= PAT_WIN) begin
      r_next.pat = PAT_HUNT;
    end

    // wake frame decoder: byte start falling edge, then eight centre samples
    if (!r_reg.fr_active) begin
      if (rx_bit(r_reg.prev.rx_sym) && !rx_bit(r_reg.sync2.rx_sym)) begin
        r_next.fr_active = 1'b1;
        r_next.fr_cnt    = FR_FIRST;
        r_next.fr_bits   = '0;
      end
    end else if (r_reg.fr_cnt != 4'h0) begin
      r_next.fr_cnt = r_reg.fr_cnt - 1'b1;
    end else if (r_reg.fr_bits == 4'h7) begin
      r_next.fr_active = 1'b0;
      if ({r_reg.fr_shift[6:0], rx_bit(r_reg.sync2.rx_sym)} == exp_byte) begin
        if (r_reg.fr_idx == FR_LAST) begin
          frame_hit     = 1'b1; // RULE8
          r_next.fr_idx = '0;
        end else begin
          r_next.fr_idx = r_reg.fr_idx + 1'b1;
        end
      end else begin
        r_next.fr_idx = {4'h0, ({r_reg.fr_shift[6:0], rx_bit(r_reg.sync2.rx_sym)} == 8'hff)};
      end
    end else begin
      r_next.fr_shift = {r_reg.fr_shift[6:0], rx_bit(r_reg.sync2.rx_sym)};
      r_next.fr_bits  = r_reg.fr_bits + 1'b1;
      r_next.fr_cnt   = FR_BIT;
    end

    // wake flags: set wins over any clear
    remote_ev  = low_power && ((pattern_hit && r_reg.ctrl[CTRL_PATTERN_EN]) || // RULE5 RULE6
                               (frame_hit && r_reg.ctrl[CTRL_FRAME_EN])); // RULE9
    clr_local  = normal || (wr_acc && paddr_i == REG_WAKE_CLR_OFS && pwdata_i[0]);
    clr_remote = normal || (wr_acc && paddr_i == REG_WAKE_CLR_OFS && pwdata_i[1]);
    r_next.local_wake  = local_ev || (r_reg.local_wake && !clr_local);
    r_next.remote_wake = remote_ev || (r_reg.remote_wake && !clr_remote);
    if (remote_ev) begin
      r_next.remote_last = 1'b1;
    end else if (local_ev) begin
      r_next.remote_last = 1'b0;
    end
    wake_flag = r_reg.local_wake || r_reg.remote_wake;
    r_next.wake_pulse = (local_ev || remote_ev) && !wake_flag; // RULE22
    if (r_next.wake_pulse) begin
      r_next.mode_pin_since_wake = 1'b0;
    end else if (r_reg.sync2.mode_pin) begin
      r_next.mode_pin_since_wake = 1'b1;
    end

    // receiver pins
    if (low_power) begin
      r_next.rxd     = !wake_flag; // RULE2
      r_next.rxact_n = !wake_flag; // RULE2
    end else begin
      r_next.rxd     = (r_reg.sync2.rx_sym != SYM_DATA0); // RULE2
      r_next.rxact_n = (r_reg.sync2.rx_sym == SYM_IDLE); // RULE2 RULE3
    end

    // status word
    status                 = '0;
    status[ST_LOCAL_WAKE]  = r_reg.local_wake;
    status[ST_REMOTE_WAKE] = r_reg.remote_wake;
    status[ST_UNUSED_HIGH] = 1'b1;
    status[ST_LATCH_HI:ST_LATCH_LO] = r_reg.shadow;
    status[ST_GUARDIAN]    = normal && r_reg.bge_latch;
    status[23:16]          = VER_ANALOG;
    status[31:24]          = VER_DIGITAL;

    // serial read-out on the mode pin
    latch_set = {flags_i.uv_io, flags_i.uv_cc, flags_i.uv_bat, r_reg.timeout,
                 flags_i.thermal_warning, flags_i.thermal_shutdown, flags_i.bus_error,
                 flags_i.power_on};
    latch_clr      = '0;
    r_next.ro_done = 1'b0;
    if (mode_fall || mode_rise) begin
      r_next.mc_cnt = '0;
    end else if (r_reg.mc_cnt < MC_LIMIT) begin
      r_next.mc_cnt = r_reg.mc_cnt + 1'b1;
    end
    if (mode_fall && !r_reg.ro_active) begin
      r_next.ro_active  = 1'b1; // RULE16
      r_next.ro_idx     = '0; // RULE19
      r_next.ro_read    = 32'h0000_0001;
      r_next.ro_bit_n   = !status[0]; // RULE15
    end else if (mode_fall) begin
      if (r_reg.ro_idx != 5'h1f) begin
        r_next.ro_idx = r_reg.ro_idx + 1'b1; // RULE19
      end
      r_next.ro_read[r_next.ro_idx] = 1'b1;
      r_next.ro_bit_n = !status[r_next.ro_idx]; // RULE15 RULE13
    end else if (r_reg.ro_active && r_reg.mc_cnt == MC_LIMIT) begin
      r_next.ro_active = 1'b0; // RULE17
      r_next.ro_done   = 1'b1; // RULE17
      for (int i = ST_CLEAR_LO; i <= ST_LATCH_HI; i++) begin
        latch_clr[i] = r_reg.ro_read[i] && !latch_set[i]; // RULE18
      end
    end
    if (mode_rise && r_reg.ro_active && normal) begin
      r_next.bge_latch = r_reg.sync2.guardian_tx_enable;
    end
    r_next.shadow = (r_reg.shadow & ~latch_clr) | latch_set;

    // error pin
    if (r_reg.ro_active) begin
      r_next.err_n = r_reg.ro_bit_n; // RULE15
    end else if (!r_reg.sync2.standby_n || low_power) begin
      r_next.err_n = !wake_flag; // RULE12 RULE13
    end else if (r_reg.sync2.mode_pin || r_reg.mode_pin_since_wake || !wake_flag) begin
      r_next.err_n = !err_flag; // RULE12 RULE13 RULE14
    end else begin
      r_next.err_n = !r_reg.remote_last; // RULE14
    end

    // register bus: data and error prepared in the setup cycle
    if (psel_i && !penable_i) begin
      r_next.slverr = !addr_mapped(paddr_i);
      case (paddr_i)
        REG_CTRL_OFS:   r_next.prdata = {30'h0, r_reg.ctrl};
        REG_FLAGS_OFS:  r_next.prdata = {24'h0, r_reg.ro_active, r_reg.timeout, err_flag,
                                         r_reg.wake_filt, r_reg.remote_last,
                                         r_reg.mode_pin_since_wake, r_reg.remote_wake,
                                         r_reg.local_wake};
        REG_STATUS_OFS: r_next.prdata = status;
        default:        r_next.prdata = 32'h0;
      endcase
    end
    if (wr_acc && paddr_i == REG_CTRL_OFS) begin
      r_next.ctrl = pwdata_i[1:0];
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      r_reg           <= '0;
      r_reg.wake_filt <= 1'b1;
      r_reg.rxd       <= 1'b1;
      r_reg.rxact_n   <= 1'b1;
      r_reg.err_n     <= 1'b1;
      r_reg.ro_bit_n  <= 1'b1;
      r_reg.inh_oe    <= 1'b1;
      r_reg.ctrl      <= CTRL_RESET;
      r_reg.tx        <= TX_LOW_POWER_IDLE;
      r_reg.pat       <= PAT_HUNT;
    end else begin
      r_reg <= r_next;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign tx_sym_o                   = r_reg.tx;
  assign rxd_o                      = r_reg.rxd;
  assign receive_activity_n_o       = r_reg.rxact_n;
  assign regulator_inhibit_out_o    = 1'b1;
  assign regulator_inhibit_out_oe_o = r_reg.inh_oe; // RULE4
  assign error_out_n_o              = r_reg.err_n;
  assign wake_pull_up_o             = r_reg.wake_filt; // RULE11
  assign tx_timeout_o               = r_reg.timeout;
  assign error_flag_o               = r_reg.timeout || (|flags_i[6:1]); // RULE20
  assign force_standby_o            = r_reg.wake_pulse; // RULE22
  assign uv_clear_o                 = r_reg.wake_pulse; // RULE22
  assign mode_hold_o                = r_reg.ro_active; // RULE16
  assign readout_done_o             = r_reg.ro_done;
  assign prdata_o                   = r_reg.prdata;
  assign pready_o                   = psel_i && penable_i;
  assign pslverr_o                  = psel_i && penable_i && r_reg.slverr;

endmodule : xcvr_ctrl

// file: hdl/xcvr_ctrl_pkg.sv
// package: constants, enums and carriers of the transceiver control logic
package xcvr_ctrl_pkg;

  // ***************************************************************
  // clock and timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS       = 20;
  localparam int TX_ACTIVE_LIMIT_NS  = 1500000;
  localparam int TX_ACTIVE_LIMIT_CYC = (TX_ACTIVE_LIMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_FILTER_NS      = 10000;
  localparam int WAKE_FILTER_CYC     = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MODE_CHANGE_NS      = 20000;
  localparam int MODE_CHANGE_CYC     = (MODE_CHANGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAT_PHASE_MIN_NS    = 1000;
  localparam int PAT_PHASE_MIN_CYC   = (PAT_PHASE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAT_WINDOW_NS       = 50000;
  localparam int PAT_WINDOW_CYC      = PAT_WINDOW_NS / CLK_PERIOD_NS;
  localparam int FRAME_BIT_NS        = 100;
  localparam int FRAME_BIT_CYC       = FRAME_BIT_NS / CLK_PERIOD_NS;

  // ***************************************************************
  // wake frame payload: bit i set means byte i is 8'hff, else 8'h00
  // ***************************************************************
  localparam int          FRAME_BYTES    = 32;
  localparam logic [31:0] WAKE_FRAME_MAP = 32'hf83e7c1f;

  // ***************************************************************
  // register map (byte addresses) and reset values
  // ***************************************************************
  localparam logic [7:0] REG_CTRL_OFS     = 8'h00;
  localparam logic [7:0] REG_FLAGS_OFS    = 8'h04;
  localparam logic [7:0] REG_WAKE_CLR_OFS = 8'h08;
  localparam logic [7:0] REG_STATUS_OFS   = 8'h0c;
  localparam logic [1:0] CTRL_RESET       = 2'h3;
  localparam int         CTRL_PATTERN_EN  = 0;
  localparam int         CTRL_FRAME_EN    = 1;

  // ***************************************************************
  // status word fields
  // ***************************************************************
  localparam int ST_LOCAL_WAKE  = 0;
  localparam int ST_REMOTE_WAKE = 1;
  localparam int ST_UNUSED_HIGH = 2;
  localparam int ST_LATCH_LO    = 3;
  localparam int ST_CLEAR_LO    = 4;
  localparam int ST_LATCH_HI    = 10;
  localparam int ST_GUARDIAN    = 11;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [2:0] {
    MODE_NORMAL, MODE_RX_ONLY, MODE_STANDBY, MODE_GOTOSLEEP, MODE_SLEEP
  } op_mode_t;

  typedef enum logic [1:0] {SYM_IDLE, SYM_DATA0, SYM_DATA1} bus_sym_t;

  typedef enum logic [1:0] {TX_LOW_POWER_IDLE, TX_IDLE, TX_DATA0, TX_DATA1} tx_sym_t;

  typedef enum logic [1:0] {PAT_HUNT, PAT_FIRST_D0, PAT_GAP, PAT_SECOND_D0} pat_state_t;

  typedef struct packed {
    logic     mode_pin;
    logic     standby_n;
    logic     txd;
    logic     transmit_enable_n;
    logic     guardian_tx_enable;
    logic     wake_pin;
    bus_sym_t rx_sym;
  } pins_t;

  // order follows status bits S3..S10 with the timeout slot taken out
  typedef struct packed {
    logic uv_io;
    logic uv_cc;
    logic uv_bat;
    logic thermal_warning;
    logic thermal_shutdown;
    logic bus_error;
    logic power_on;
  } flags_t;

endpackage : xcvr_ctrl_pkg

// file: test/xcvr_bus_far.sv
// far-side bus model: sends basic or alternative wake patterns
`timescale 1ns/1ps
module xcvr_bus_far (
  input  wire logic               clk_sys_i,
  input  wire logic               go_i,
  input  wire logic               alt_i,
  output xcvr_ctrl_pkg::bus_sym_t sym_o
);
  import xcvr_ctrl_pkg::*;
  int step_reg;
  always @(posedge clk_sys_i) begin
    step_reg <= go_i ? 1 : ((step_reg inside {[1:179]}) ? step_reg + 1 : 0);
    if (step_reg inside {[1:60], [121:180]}) begin
      sym_o <= SYM_DATA0;
    end else if (step_reg > 60 && alt_i) begin
      sym_o <= SYM_DATA1;
    end else begin
      sym_o <= SYM_IDLE;
    end
  end
endmodule : xcvr_bus_far

// file: test/xcvr_ctrl_chk.sv
// checker: port assertions of the transceiver control logic
`timescale 1ns/1ps
module xcvr_ctrl_chk (
  input wire logic                    clk_sys_i,
  input wire logic                    srst_i,
  input wire xcvr_ctrl_pkg::op_mode_t op_mode_i,
  input wire xcvr_ctrl_pkg::pins_t    pins_i,
  input wire xcvr_ctrl_pkg::flags_t   flags_i,
  input wire logic [1:0]              tx_sym_o,
  input wire logic                    regulator_inhibit_out_oe_o,
  input wire logic                    error_out_n_o,
  input wire logic                    tx_timeout_o,
  input wire logic                    error_flag_o,
  input wire logic                    force_standby_o,
  input wire logic                    uv_clear_o,
  input wire logic                    mode_hold_o
);
  import xcvr_ctrl_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  sequence low_power_s;
    op_mode_i inside {MODE_STANDBY, MODE_GOTOSLEEP, MODE_SLEEP};
  endsequence
  sequence normal_quiet_s;
    (op_mode_i == MODE_NORMAL && pins_i.standby_n && pins_i.mode_pin && !mode_hold_o) [*4];
  endsequence
  a_low_power_idle: assert property (low_power_s [*2] |-> tx_sym_o == TX_LOW_POWER_IDLE)
    else $error("transmitter not in low-power idle");
  a_rx_only_idle: assert property ((op_mode_i == MODE_RX_ONLY) [*2] |-> tx_sym_o == TX_IDLE)
    else $error("transmitter not idle in receive-only");
  a_sleep_float: assert property ((op_mode_i == MODE_SLEEP) [*2] |-> !regulator_inhibit_out_oe_o)
    else $error("inhibit driven in sleep");
  a_awake_drive: assert property ((op_mode_i != MODE_SLEEP) [*2] |-> regulator_inhibit_out_oe_o)
    else $error("inhibit released outside sleep");
  a_error_or: assert property (error_flag_o == (tx_timeout_o || (|flags_i[6:1])))
    else $error("error flag not the fault sum");
  a_timeout_block: assert property (tx_timeout_o [*2] |-> tx_sym_o inside {TX_LOW_POWER_IDLE, TX_IDLE})
    else $error("transmitter active during timeout");
  a_timeout_clear: assert property (pins_i.transmit_enable_n [*4] |-> !tx_timeout_o)
    else $error("timeout kept with enable high");
  a_wake_pulse: assert property (force_standby_o |-> uv_clear_o ##1 !force_standby_o)
    else $error("standby and clear pulse mismatch");
  a_error_pin_normal: assert property (normal_quiet_s ##0 ($stable(error_flag_o) && $past(error_flag_o, 2) == error_flag_o) |-> error_out_n_o == !error_flag_o)
    else $error("error pin wrong in normal mode");
endmodule : xcvr_ctrl_chk

// file: test/xcvr_ctrl_tb.sv
// testbench: transceiver control logic through its pins and register bus
`timescale 1ns/1ps
module xcvr_ctrl_tb;
  import xcvr_ctrl_pkg::*;
  logic        clk_sys_i, srst_i, psel_i, penable_i, pwrite_i, pat_go, pat_alt, err;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [1:0]  tx_sym_o;
  logic        rxd_o, receive_activity_n_o, regulator_inhibit_out_o, regulator_inhibit_out_oe_o;
  logic        error_out_n_o, wake_pull_up_o, tx_timeout_o, error_flag_o, force_standby_o;
  logic        uv_clear_o, mode_hold_o, readout_done_o, pready_o, pslverr_o;
  op_mode_t    op_mode_i;
  pins_t       pin_r, pins_i;
  flags_t      flags_i;
  bus_sym_t    far_sym;
  int          error_cnt, samples_checked;
  logic [7:0]  tx_tab [8] = '{8'h12, 8'h17, 8'h05, 8'h19, 8'h31, 8'h50, 8'h70, 8'h90};
  assign pins_i = {pin_r[7:2], far_sym};
  xcvr_ctrl #(.TX_LIMIT_CYC(20)) dut (.*);
  xcvr_bus_far far (.clk_sys_i(clk_sys_i), .go_i(pat_go), .alt_i(pat_alt), .sym_o(far_sym));
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= a;
    pwdata_i <= d;
    cyc(1);
    penable_i <= 1'b1;
    do cyc(1); while (pready_o !== 1'b1);
    rd  = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    cyc(1);
  endtask : apb
  task automatic send(input logic alt);
    pat_alt <= alt;
    pat_go  <= 1'b1;
    cyc(1);
    pat_go <= 1'b0;
  endtask : send
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pat_go, pat_alt} = '0;
    op_mode_i = MODE_NORMAL;
    pin_r     = 8'hdc;
    flags_i   = '0;
    srst_i    = 1'b1;
    cyc(20);
    srst_i <= 1'b0;
    cyc(2);
    apb(0, REG_CTRL_OFS, 0);
    chk(rd, {30'h0, CTRL_RESET});
    apb(1, REG_CTRL_OFS, 32'h1);
    apb(0, REG_CTRL_OFS, 0);
    chk(rd, 32'h1);
    apb(1, REG_CTRL_OFS, 32'h3);
    apb(0, 8'h10, 0);
    chk(err, 1'b1);
    $display("test registers done");
    foreach (tx_tab[i]) begin
      op_mode_i <= op_mode_t'(tx_tab[i][7:5]);
      {pin_r[3], pin_r[4], pin_r[5]} <= tx_tab[i][4:2];
      cyc(5);
      chk(tx_sym_o, tx_tab[i][1:0]);
      chk(regulator_inhibit_out_oe_o, tx_tab[i][7:5] != 3'h4);
    end
    $display("test transmit table done");
    op_mode_i <= MODE_NORMAL;
    cyc(30);
    chk(tx_timeout_o, 1'b1);
    chk(tx_sym_o, TX_IDLE);
    chk(error_out_n_o, 1'b0);
    pin_r.transmit_enable_n <= 1'b1;
    flags_i <= 7'h02;
    cyc(5);
    chk(tx_timeout_o, 1'b0);
    chk(error_out_n_o, 1'b0);
    flags_i <= '0;
    cyc(3);
    chk(error_out_n_o, 1'b1);
    chk({rxd_o, receive_activity_n_o}, 2'b11);
    $display("test timeout and error pin done");
    send(1'b1);
    cyc(30);
    chk({rxd_o, receive_activity_n_o}, 2'b00);
    cyc(60);
    chk({rxd_o, receive_activity_n_o}, 2'b10);
    op_mode_i <= MODE_STANDBY;
    cyc(110);
    chk({rxd_o, receive_activity_n_o}, 2'b00);
    chk(error_out_n_o, 1'b0);
    apb(0, REG_FLAGS_OFS, 0);
    chk({rd[3], rd[1:0]}, 3'b110);
    apb(1, REG_WAKE_CLR_OFS, 32'h3);
    op_mode_i <= MODE_SLEEP;
    send(1'b0);
    cyc(200);
    apb(0, REG_FLAGS_OFS, 0);
    chk(rd[1:0], 2'b10);
    $display("test remote wake done");
    apb(1, REG_WAKE_CLR_OFS, 32'h3);
    pin_r.wake_pin <= 1'b0;
    cyc(300);
    pin_r.wake_pin <= 1'b1;
    cyc(520);
    apb(0, REG_FLAGS_OFS, 0);
    chk(rd[1:0], 2'b00);
    chk(wake_pull_up_o, 1'b1);
    pin_r.wake_pin <= 1'b0;
    cyc(520);
    chk(wake_pull_up_o, 1'b0);
    apb(0, REG_FLAGS_OFS, 0);
    chk(rd[1:0], 2'b01);
    pin_r.mode_pin <= 1'b0;
    cyc(6);
    chk({mode_hold_o, error_out_n_o}, 2'b10);
    pin_r.mode_pin <= 1'b1;
    cyc(9);
    pin_r.mode_pin <= 1'b0;
    cyc(6);
    chk(error_out_n_o, 1'b1);
    cyc(1100);
    chk({mode_hold_o, error_out_n_o}, 2'b00);
    $display("test wake and read-out done");
    stop_test();
  end
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
endmodule : xcvr_ctrl_tb
bind xcvr_ctrl xcvr_ctrl_chk u_chk (.*);
